//--- hw/rssopt_top.sv
// Contract
// RULE_01: reset cause flags are read-only, set only on reset entry.
// RULE_02: a reset forced by the debug host leaves every cause flag clear.
// RULE_03: watchdog on, cause-flag write other than 0x55 or 0xAA resets.
// RULE_04: 0x55 then 0xAA clears the watchdog, flags unchanged.
// RULE_05: power-on sets bits 7 and 1, others clear.
// RULE_06: low-voltage reset sets bit 1, keeps bit 7, clears the rest.
// RULE_07: other resets set active sources in bits 6..3, clear bits 7 and 1.
// RULE_08: bit 6 marks a low level on the external reset pin.
// RULE_09: bit 5 marks watchdog timeout; none while watchdog disabled.
// RULE_10: illegal opcode, disabled stop or background, resets and sets bit 4.
// RULE_11: access to unimplemented address resets and sets bit 3.
// RULE_12: force-reset register written only by debug host, reads 0x00.
// RULE_13: debug host writing 1 to force bit resets the whole chip.
// RULE_14: options one takes only its first write after each reset.
// RULE_15: software writes options one once during its initialisation.
// RULE_16: options one bits 7:6 with clock select set watchdog timeout.
// RULE_17: stop enable bit 5; stop while clear is an illegal opcode.
// RULE_18: options one bit 2 routes two-wire pins to first or alternate pair.
// RULE_19: options two clock select picks slow tick or bus clock.
// RULE_20: unimplemented bits read zero, writes to them do nothing.
`timescale 1ns/1ps
`default_nettype none
module rssopt_top #(
  parameter int WD_BUS_SHIFT = 8
) (
  input  wire logic                clk,
  input  wire logic                rstn,
  input  wire logic                bus_rd,
  input  wire logic                bus_wr,
  input  wire rssopt_pkg::rssopt_addr_t bus_addr,
  input  wire rssopt_pkg::rssopt_byte_t bus_wdata,
  output rssopt_pkg::rssopt_byte_t bus_rdata,
  input  wire logic                dbg_wr,
  input  wire rssopt_pkg::rssopt_byte_t dbg_wdata,
  input  wire logic                reset_pin_n,
  input  wire logic                supply_low,
  input  wire logic                lpo_clk,
  input  wire logic                low_voltage_reset_enable,
  input  wire logic                background_mode_enable,
  input  wire logic                cpu_bad_opcode,
  input  wire logic                cpu_stop_exec,
  input  wire logic                cpu_background_instruction_exec,
  input  wire logic                cpu_bad_address,
  output logic                     mcu_reset_n,
  output logic                     stop_enable,
  output logic                     watchdog_enable,
  input  wire logic                iic_sda_o,
  input  wire logic                iic_sda_oe,
  input  wire logic                iic_scl_o,
  input  wire logic                iic_scl_oe,
  output logic                     iic_sda_i,
  output logic                     iic_scl_i,
  input  wire logic                pa_sda_i,
  input  wire logic                pa_scl_i,
  output logic                     pa_sda_o,
  output logic                     pa_sda_oe,
  output logic                     pa_scl_o,
  output logic                     pa_scl_oe,
  input  wire logic                pb_sda_i,
  input  wire logic                pb_scl_i,
  output logic                     pb_sda_o,
  output logic                     pb_sda_oe,
  output logic                     pb_scl_o,
  output logic                     pb_scl_oe
);
  import rssopt_pkg::*;

  logic [6:0]           pad_raw;
  logic [6:0]           pad_s;
  logic                 pin_n_s;
  logic                 supply_low_s;
  logic                 lpo_s;
  rssopt_state_t        state_ff;
  rssopt_state_t        nxt_state;
  logic [HOLD_CW-1:0]   hold_cnt_ff;
  logic [HOLD_CW-1:0]   nxt_hold_cnt;
  rssopt_byte_t         flags_ff;
  rssopt_byte_t         nxt_flags;
  rssopt_byte_t         opt1_ff;
  rssopt_byte_t         nxt_opt1;
  logic                 opt1_lock_ff;
  logic                 nxt_opt1_lock;
  rssopt_byte_t         opt2_ff;
  rssopt_byte_t         nxt_opt2;
  logic                 opt2_lock_ff;
  logic                 nxt_opt2_lock;
  logic                 svc_arm_ff;
  logic                 nxt_svc_arm;
  logic                 lpo_prev_ff;
  logic                 nxt_lpo_prev;
  rssopt_byte_t         nxt_rdata;
  logic                 in_run;
  logic                 wr_flags;
  logic                 svc_key;
  logic                 bad_svc;
  logic                 svc_done;
  logic                 wd_en;
  logic                 wd_timeout;
  logic                 wd_clr;
  logic                 pin_src;
  logic                 lv_src;
  logic                 wd_src;
  logic                 op_src;
  logic                 ad_src;
  logic                 dbg_src;
  logic                 any_src;
  logic                 pin_sel;

  // pads and the slow clock are asynchronous to clk
  assign pad_raw = {reset_pin_n, supply_low, lpo_clk, pa_sda_i, pa_scl_i, pb_sda_i, pb_scl_i};

  rssopt_sync #(
    .WIDTH   (7),
    .RST_VAL (7'h4F)
  ) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .d    (pad_raw),
    .q    (pad_s)
  );

  assign pin_n_s      = pad_s[6];
  assign supply_low_s = pad_s[5];
  assign lpo_s        = pad_s[4];

  rssopt_wdog #(
    .SHIFT (WD_BUS_SHIFT),
    .CW    (20)
  ) u_wdog (
    .clk         (clk),
    .rstn        (rstn),
    .clr         (wd_clr),
    .timeout_sel (opt1_ff[OPT1_TMO_HI:OPT1_TMO_LO]),
    .bus_clk_sel (opt2_ff[OPT2_CLKSEL]),
    .lpo_tick    (lpo_s & ~lpo_prev_ff),
    .enabled     (wd_en),
    .timeout     (wd_timeout)
  );

  assign in_run   = (state_ff == ST_RUN);
  assign wr_flags = in_run & bus_wr & (bus_addr == ADDR_FLAGS);
  assign svc_key  = (bus_wdata == SVC_KEY1) | (bus_wdata == SVC_KEY2);
  assign bad_svc  = wr_flags & wd_en & ~svc_key; // RULE_03
  assign svc_done = wr_flags & svc_arm_ff & (bus_wdata == SVC_KEY2); // RULE_04
  // the core is held in reset too, so the count restarts from zero on release
  assign wd_clr   = ~in_run | svc_done;

  assign pin_src = ~pin_n_s; // RULE_08
  assign lv_src  = low_voltage_reset_enable & supply_low_s; // RULE_06
  assign wd_src  = wd_timeout | bad_svc; // RULE_09
  assign op_src  = cpu_bad_opcode | (cpu_stop_exec & ~opt1_ff[OPT1_STOP])
                 | (cpu_background_instruction_exec & ~background_mode_enable); // RULE_10
  assign ad_src  = cpu_bad_address; // RULE_11
  assign dbg_src = dbg_wr & dbg_wdata[DBG_FORCE_BIT]; // RULE_13
  assign any_src = in_run & (pin_src | lv_src | wd_src | op_src | ad_src | dbg_src);

  // reset sequencer and cause capture
  always_comb begin
    nxt_state    = state_ff;
    nxt_hold_cnt = hold_cnt_ff;
    nxt_flags    = flags_ff;
    unique case (state_ff)
      ST_RUN: begin
        if (any_src) begin
          nxt_state    = ST_HOLD;
          nxt_hold_cnt = HOLD_CW'(RST_HOLD_CYC - 1);
          if (dbg_src) begin
            nxt_flags = 8'h00; // RULE_02
          end else if (lv_src) begin
            nxt_flags = '0;
            nxt_flags[FLG_POWER_ON] = flags_ff[FLG_POWER_ON];
            nxt_flags[FLG_LOW_V]    = 1'b1; // RULE_06
          end else begin
            nxt_flags = '0; // RULE_07
            nxt_flags[FLG_PIN]      = pin_src; // RULE_08
            nxt_flags[FLG_WDOG]     = wd_src; // RULE_09
            nxt_flags[FLG_BAD_OP]   = op_src; // RULE_10
            nxt_flags[FLG_BAD_ADDR] = ad_src; // RULE_11
          end
        end
      end
      ST_HOLD: begin
        // pin and low supply stretch the hold until they clear
        if (hold_cnt_ff != '0) begin
          nxt_hold_cnt = hold_cnt_ff - HOLD_CW'(1);
        end else if (!pin_src && !lv_src) begin
          nxt_state = ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff    <= ST_HOLD;
      hold_cnt_ff <= HOLD_CW'(RST_HOLD_CYC - 1);
      flags_ff    <= FLAGS_POWER_ON_VAL; // RULE_05
    end else begin
      state_ff    <= nxt_state;
      hold_cnt_ff <= nxt_hold_cnt;
      flags_ff    <= nxt_flags; // RULE_01
    end
  end

  // options, service arming and read port
  always_comb begin
    nxt_opt1      = opt1_ff;
    nxt_opt1_lock = opt1_lock_ff;
    nxt_opt2      = opt2_ff;
    nxt_opt2_lock = opt2_lock_ff;
    nxt_svc_arm   = svc_arm_ff;
    nxt_lpo_prev  = lpo_s;
    nxt_rdata     = bus_rdata;
    if (!in_run) begin
      nxt_opt1      = OPT1_RST;
      nxt_opt1_lock = 1'b0;
      nxt_opt2      = OPT2_RST;
      nxt_opt2_lock = 1'b0;
      nxt_svc_arm   = 1'b0;
    end else if (bus_wr) begin
      // a write to the force-reset index from the core is dropped here
      if (bus_addr == ADDR_OPT1 && !opt1_lock_ff) begin
        nxt_opt1      = bus_wdata & OPT1_MASK; // RULE_20
        nxt_opt1_lock = 1'b1; // RULE_14
      end
      if (bus_addr == ADDR_OPT2 && !opt2_lock_ff) begin
        nxt_opt2      = bus_wdata & OPT2_MASK; // RULE_19
        nxt_opt2_lock = 1'b1;
      end
      if (bus_addr == ADDR_FLAGS) begin
        nxt_svc_arm = (bus_wdata == SVC_KEY1); // RULE_04
      end
    end
    if (bus_rd) begin
      unique case (bus_addr)
        ADDR_FLAGS: nxt_rdata = flags_ff;
        ADDR_DBG:   nxt_rdata = DBG_READ_VAL; // RULE_12
        ADDR_OPT1:  nxt_rdata = opt1_ff;
        ADDR_OPT2:  nxt_rdata = opt2_ff;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      opt1_ff      <= OPT1_RST;
      opt1_lock_ff <= 1'b0;
      opt2_ff      <= OPT2_RST;
      opt2_lock_ff <= 1'b0;
      svc_arm_ff   <= 1'b0;
      lpo_prev_ff  <= 1'b0;
      bus_rdata    <= 8'h00;
    end else begin
      opt1_ff      <= nxt_opt1;
      opt1_lock_ff <= nxt_opt1_lock;
      opt2_ff      <= nxt_opt2;
      opt2_lock_ff <= nxt_opt2_lock;
      svc_arm_ff   <= nxt_svc_arm;
      lpo_prev_ff  <= nxt_lpo_prev;
      bus_rdata    <= nxt_rdata;
    end
  end

  assign mcu_reset_n     = in_run;
  assign stop_enable     = opt1_ff[OPT1_STOP]; // RULE_17
  assign watchdog_enable = wd_en;

  // two-wire pin routing; inputs come through the synchroniser
  assign pin_sel   = opt1_ff[OPT1_PINSEL]; // RULE_18
  assign pa_sda_o  = iic_sda_o;
  assign pa_scl_o  = iic_scl_o;
  assign pb_sda_o  = iic_sda_o;
  assign pb_scl_o  = iic_scl_o;
  assign pa_sda_oe = iic_sda_oe & ~pin_sel;
  assign pa_scl_oe = iic_scl_oe & ~pin_sel;
  assign pb_sda_oe = iic_sda_oe & pin_sel;
  assign pb_scl_oe = iic_scl_oe & pin_sel;
  assign iic_sda_i = pin_sel ? pad_s[1] : pad_s[3];
  assign iic_scl_i = pin_sel ? pad_s[0] : pad_s[2];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_FLAGS_ONLY_ON_ENTRY: assert property ( // RULE_01
    !$stable(flags_ff) |-> $past(any_src))
    else $error("cause flags changed outside reset entry");

  AST_DEBUG_CLEARS: assert property ( // RULE_02
    any_src && dbg_src |=> flags_ff == 8'h00 && !mcu_reset_n)
    else $error("debug reset left a flag set");

  AST_BAD_SERVICE: assert property ( // RULE_03
    in_run && bad_svc && !dbg_src && !lv_src |=> !mcu_reset_n && flags_ff[FLG_WDOG])
    else $error("bad service write did not reset");

  AST_SERVICE_KEEPS: assert property ( // RULE_04
    svc_done && !any_src |=> $stable(flags_ff) && mcu_reset_n)
    else $error("service sequence disturbed flags");

  AST_LOW_V_ENTRY: assert property ( // RULE_06
    any_src && lv_src && !dbg_src |=> flags_ff[FLG_LOW_V]
      && flags_ff[FLG_POWER_ON] == $past(flags_ff[FLG_POWER_ON]) && flags_ff[6:2] == 5'h0)
    else $error("low-voltage entry flags wrong");

  AST_OTHER_ENTRY: assert property ( // RULE_07
    any_src && !lv_src && !dbg_src |=> !flags_ff[FLG_POWER_ON] && !flags_ff[FLG_LOW_V])
    else $error("other reset kept bit 7 or 1");

  AST_PIN_FLAG: assert property ( // RULE_08
    any_src && !lv_src && !dbg_src |=> flags_ff[FLG_PIN] == $past(pin_src))
    else $error("pin flag mismatch");

  AST_NO_WD_WHEN_OFF: assert property ( // RULE_09
    !wd_en |=> !wd_timeout)
    else $error("watchdog fired while disabled");

  AST_STOP_ILLEGAL: assert property ( // RULE_10
    in_run && cpu_stop_exec && !stop_enable && !dbg_src && !lv_src
      |=> !mcu_reset_n && flags_ff[FLG_BAD_OP])
    else $error("disabled stop did not reset");

  AST_DBG_READS_ZERO: assert property ( // RULE_12
    bus_rd && bus_addr == ADDR_DBG |=> bus_rdata == 8'h00)
    else $error("force-reset register read nonzero");

  AST_FORCE_HOLD: assert property ( // RULE_13
    any_src && dbg_src |=> !mcu_reset_n [*8])
    else $error("forced reset too short");

  AST_OPT1_LOCKED: assert property ( // RULE_14
    in_run && opt1_lock_ff |=> $stable(opt1_ff))
    else $error("options one changed after lock");

  COV_SERVICE: cover property (svc_done);
  COV_DEBUG_RESET: cover property (any_src && dbg_src);
  COV_WD_TIMEOUT: cover property (in_run && wd_timeout);
  COV_OPT1_WRITE: cover property (in_run && bus_wr && bus_addr == ADDR_OPT1 && !opt1_lock_ff);
endmodule
`default_nettype wire

//--- hw/rssopt_pkg.sv
package rssopt_pkg;

  typedef logic [1:0] rssopt_addr_t;
  typedef logic [7:0] rssopt_byte_t;

  typedef enum logic [1:0] {
    ST_RUN  = 2'b01,
    ST_HOLD = 2'b10
  } rssopt_state_t;

  // register indices on the core bus
  localparam rssopt_addr_t ADDR_FLAGS = 2'h0;
  localparam rssopt_addr_t ADDR_DBG   = 2'h1;
  localparam rssopt_addr_t ADDR_OPT1  = 2'h2;
  localparam rssopt_addr_t ADDR_OPT2  = 2'h3;

  // reset_cause_flags bit positions
  localparam int FLG_POWER_ON = 7;
  localparam int FLG_PIN      = 6;
  localparam int FLG_WDOG     = 5;
  localparam int FLG_BAD_OP   = 4;
  localparam int FLG_BAD_ADDR = 3;
  localparam int FLG_LOW_V    = 1;
  localparam rssopt_byte_t FLAGS_POWER_ON_VAL = 8'h82;

  // debug_forced_reset
  localparam int           DBG_FORCE_BIT = 0;
  localparam rssopt_byte_t DBG_READ_VAL  = 8'h00;

  // system_options_one fields
  localparam int           OPT1_TMO_HI = 7;
  localparam int           OPT1_TMO_LO = 6;
  localparam int           OPT1_STOP   = 5;
  localparam int           OPT1_PINSEL = 2;
  localparam rssopt_byte_t OPT1_MASK   = 8'hE4;
  localparam rssopt_byte_t OPT1_RST    = 8'hC0;

  // system_options_two fields
  localparam int           OPT2_CLKSEL = 7;
  localparam rssopt_byte_t OPT2_MASK   = 8'h80;
  localparam rssopt_byte_t OPT2_RST    = 8'h00;

  // watchdog service keys
  localparam rssopt_byte_t SVC_KEY1 = 8'h55;
  localparam rssopt_byte_t SVC_KEY2 = 8'hAA;

  // watchdog limits in slow-clock ticks per timeout select
  localparam int WD_TICKS_1 = 32'h0000_0020;
  localparam int WD_TICKS_2 = 32'h0000_0100;
  localparam int WD_TICKS_3 = 32'h0000_0400;

  // reset hold time
  localparam int CLK_PERIOD_NS = 20;
  localparam int RST_HOLD_NS   = 320;
  localparam int RST_HOLD_CYC  = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CW       = 5;

endpackage

//--- hw/rssopt_sync.sv
`timescale 1ns/1ps
`default_nettype none
module rssopt_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  import rssopt_pkg::*;

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] nxt_q;

  always_comb begin
    nxt_meta = d;
    nxt_q    = meta_ff;
  end

  // first stage feeds the second stage only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_ff <= RST_VAL;
      q       <= RST_VAL;
    end else begin
      meta_ff <= nxt_meta;
      q       <= nxt_q;
    end
  end
endmodule
`default_nettype wire

//--- hw/rssopt_wdog.sv
`timescale 1ns/1ps
`default_nettype none
module rssopt_wdog #(
  parameter int SHIFT = 8,
  parameter int CW    = 20
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       clr,
  input  wire logic [1:0] timeout_sel,
  input  wire logic       bus_clk_sel,
  input  wire logic       lpo_tick,
  output logic            enabled,
  output logic            timeout
);
  import rssopt_pkg::*;

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic          nxt_timeout;
  logic [CW-1:0] limit;
  logic          tick;

  function automatic logic [CW-1:0] wd_limit(input logic [1:0] sel, input logic bsel);
    logic [CW-1:0] base;
    case (sel)
      2'b01:   base = CW'(WD_TICKS_1);
      2'b10:   base = CW'(WD_TICKS_2);
      default: base = CW'(WD_TICKS_3);
    endcase
    wd_limit = bsel ? (base << SHIFT) : base;
  endfunction

  // select code zero switches the watchdog off
  assign enabled = (timeout_sel != 2'b00);
  assign limit   = wd_limit(timeout_sel, bus_clk_sel); // RULE_16
  assign tick    = bus_clk_sel | lpo_tick; // RULE_19

  always_comb begin
    nxt_cnt     = cnt_ff;
    nxt_timeout = 1'b0;
    if (clr || !enabled) begin
      nxt_cnt = '0;
    end else if (tick) begin
      if (cnt_ff >= limit - CW'(1)) begin
        nxt_cnt     = '0;
        nxt_timeout = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + CW'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff  <= '0;
      timeout <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      timeout <= nxt_timeout;
    end
  end
endmodule
`default_nettype wire

//--- tb/rssopt_host.sv
`timescale 1ns/1ps
`default_nettype none
module rssopt_host (
  input  wire logic                     clk,
  input  wire rssopt_pkg::rssopt_byte_t bus_rdata,
  output var  logic                     bus_rd,
  output var  logic                     bus_wr,
  output var  rssopt_pkg::rssopt_addr_t bus_addr,
  output var  rssopt_pkg::rssopt_byte_t bus_wdata,
  output var  logic                     dbg_wr,
  output var  rssopt_pkg::rssopt_byte_t dbg_wdata
);
  import rssopt_pkg::*;
  initial begin
    bus_rd    = 1'b0;
    bus_wr    = 1'b0;
    bus_addr  = ADDR_OPT2;
    bus_wdata = 8'h00;
    dbg_wr    = 1'b0;
    dbg_wdata = 8'h00;
  end
  // idle data shows the inverse so a stale byte never passes for a fresh one
  task automatic wr(input rssopt_addr_t a, input rssopt_byte_t d);
    @(posedge clk);
    bus_wr    <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_wr    <= 1'b0;
    bus_wdata <= ~d;
  endtask
  task automatic rd(input rssopt_addr_t a, output rssopt_byte_t d);
    @(posedge clk);
    bus_rd   <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd <= 1'b0;
    @(posedge clk);
    #1;
    d = bus_rdata;
  endtask
  // force request arrives only as a decoded serial command, never from the core
  task automatic dbg(input rssopt_byte_t d);
    @(posedge clk);
    dbg_wr    <= 1'b1;
    dbg_wdata <= d;
    @(posedge clk);
    dbg_wr    <= 1'b0;
    dbg_wdata <= ~d;
  endtask
  task automatic svc();
    wr(ADDR_FLAGS, SVC_KEY1);
    wr(ADDR_FLAGS, SVC_KEY2);
  endtask
  // options one written once at start-up to lock it
  task automatic init_opt1(input rssopt_byte_t d);
    wr(ADDR_OPT1, d);
  endtask
endmodule
`default_nettype wire

//--- tb/tb_reset_status_system_options.sv
`timescale 1ns/1ps
`default_nettype none
module tb_reset_status_system_options;
  import rssopt_pkg::*;
  typedef struct {int src; rssopt_byte_t flags;} rssopt_row_t;
  logic         clk, rstn, reset_pin_n, supply_low, lv_en, bm_en;
  logic         sda_o, sda_oe, pa_sda, pb_sda, mcu_reset_n, stop_en, wd_en;
  logic         bus_rd, bus_wr, dbg_wr, iic_sda_i, pa_sda_o, pa_sda_oe, pb_sda_oe;
  logic         pa_scl_o, pa_scl_oe, pb_sda_o, pb_scl_o, pb_scl_oe, iic_scl_i;
  logic   [3:0] ev;
  logic   [5:0] lpo_div;
  logic   [7:0] low_cnt, hold_len;
  rssopt_addr_t bus_addr;
  rssopt_byte_t bus_wdata, bus_rdata, dbg_wdata, rv;
  int           bad_count, total_checks, n;
  rssopt_row_t  rows [11] = '{
    '{0, 8'h40}, '{1, 8'h10}, '{2, 8'h10}, '{3, 8'h10}, '{4, 8'h08},
    '{5, 8'h00}, '{6, 8'h20}, '{7, 8'h02}, '{8, 8'h20}, '{9, 8'h20}, '{10, 8'h20}};

  rssopt_host u_host (.clk(clk), .bus_rdata(bus_rdata), .bus_rd(bus_rd), .bus_wr(bus_wr),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .dbg_wr(dbg_wr), .dbg_wdata(dbg_wdata));

  rssopt_top #(.WD_BUS_SHIFT(0)) DUT (.clk(clk), .rstn(rstn), .bus_rd(bus_rd),
    .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .dbg_wr(dbg_wr), .dbg_wdata(dbg_wdata), .reset_pin_n(reset_pin_n),
    .supply_low(supply_low), .lpo_clk(lpo_div[5]), .low_voltage_reset_enable(lv_en),
    .background_mode_enable(bm_en), .cpu_bad_opcode(ev[0]), .cpu_stop_exec(ev[1]),
    .cpu_background_instruction_exec(ev[2]), .cpu_bad_address(ev[3]), .mcu_reset_n(mcu_reset_n),
    .stop_enable(stop_en), .watchdog_enable(wd_en), .iic_sda_o(sda_o), .iic_sda_oe(sda_oe),
    .iic_scl_o(~sda_o), .iic_scl_oe(sda_oe), .iic_sda_i(iic_sda_i), .iic_scl_i(iic_scl_i),
    .pa_sda_i(pa_sda), .pa_scl_i(pb_sda), .pa_sda_o(pa_sda_o), .pa_sda_oe(pa_sda_oe),
    .pa_scl_o(pa_scl_o), .pa_scl_oe(pa_scl_oe), .pb_sda_i(pb_sda), .pb_scl_i(pa_sda),
    .pb_sda_o(pb_sda_o), .pb_sda_oe(pb_sda_oe), .pb_scl_o(pb_scl_o), .pb_scl_oe(pb_scl_oe));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // hold length measured apart from the waits, so no cycle of it is missed
  always @(posedge clk) begin
    lpo_div <= lpo_div + 6'h01;
    low_cnt <= (mcu_reset_n === 1'b1) ? 8'h00 : low_cnt + 8'h01;
    if (mcu_reset_n === 1'b1 && low_cnt != 8'h00) hold_len <= low_cnt;
  end

  task automatic chk(input string nm, input rssopt_byte_t seen, input rssopt_byte_t exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic run_wait(input int lim);
    for (n = 0; n < lim && mcu_reset_n !== 1'b0; n++) begin
      @(posedge clk);
      #1;
    end
    chk("entry", {7'h00, mcu_reset_n}, 8'h00);
    for (n = 0; n < 400 && mcu_reset_n !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    chk("hold", {7'h00, hold_len >= 8'd16}, 8'h01);
  endtask
  task automatic fire(input int s);
    @(posedge clk);
    case (s)
      0: reset_pin_n <= 1'b0;
      1, 2, 3, 4: ev <= 4'h1 << (s - 1);
      5: u_host.dbg(8'h01);
      6: u_host.wr(ADDR_FLAGS, 8'h12);
      7: begin
        lv_en      <= 1'b1;
        supply_low <= 1'b1;
      end
      default: begin
        u_host.wr(ADDR_OPT2, 8'h80);
        // short timeout codes, only reachable on the fast tick within a row
        if (s > 8) u_host.wr(ADDR_OPT1, (s == 9) ? 8'h40 : 8'h80);
      end
    endcase
    @(posedge clk);
    ev <= 4'h0;
    repeat (5) @(posedge clk);
    reset_pin_n <= 1'b1;
    supply_low  <= 1'b0;
  endtask
  task automatic route(input rssopt_byte_t exp, input rssopt_byte_t es);
    repeat (4) @(posedge clk);
    #1;
    chk("route", {4'h0, pa_sda_oe, pb_sda_oe, pa_sda_o, iic_sda_i}, exp);
    rv = {2'h0, pa_scl_o, pb_sda_o, pb_scl_o, pa_scl_oe, pb_scl_oe, iic_scl_i};
    chk("scl", rv, es);
  endtask

  initial begin
    #(20 * 30000);
    bad_count++;
    end_of_test();
  end

  initial begin
    {rstn, supply_low, lv_en, bm_en, ev, lpo_div, low_cnt, hold_len} = '0;
    {reset_pin_n, sda_o, sda_oe, pb_sda, pa_sda} = 5'b11110;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    run_wait(50);
    for (int i = 0; i < 11; i++) begin
      fire(rows[i].src);
      run_wait(rows[i].src == 9 ? 60 : rows[i].src == 10 ? 300 : 1500);
      u_host.rd(ADDR_FLAGS, rv);
      chk("flags", rv, rows[i].flags);
      $display("test row %0d done", i);
    end
    @(posedge clk);
    rstn <= 1'b0;
    lv_en <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    run_wait(50);
    u_host.rd(ADDR_FLAGS, rv);
    chk("por", rv, FLAGS_POWER_ON_VAL);
    u_host.rd(ADDR_DBG, rv);
    chk("dbg_read", rv, 8'h00);
    u_host.rd(ADDR_OPT1, rv);
    chk("opt1_rst", rv, 8'hC0);
    chk("en_rst", {6'h00, stop_en, wd_en}, 8'h01);
    route(8'h0A, 8'h15);
    $display("test power-on done");
    fire(7);
    run_wait(100);
    u_host.rd(ADDR_FLAGS, rv);
    chk("lv_keep", rv, 8'h82);
    lv_en <= 1'b0;
    $display("test low voltage after power-on done");
    u_host.wr(ADDR_OPT2, 8'h80);
    // three services spaced under the 1024-cycle limit outlast one full period
    repeat (3) begin
      repeat (600) @(posedge clk);
      u_host.svc();
    end
    u_host.wr(ADDR_DBG, 8'h01);
    u_host.init_opt1(8'h3F);
    u_host.wr(ADDR_OPT1, 8'hC0);
    u_host.rd(ADDR_OPT1, rv);
    chk("opt1_once", rv, 8'h24);
    chk("en_set", {6'h00, stop_en, wd_en}, 8'h02);
    route(8'h07, 8'h12);
    @(posedge clk);
    // legal stop and background, and a low supply while its reset is disabled
    ev         <= 4'h6;
    bm_en      <= 1'b1;
    supply_low <= 1'b1;
    @(posedge clk);
    ev         <= 4'h0;
    supply_low <= 1'b0;
    u_host.wr(ADDR_FLAGS, 8'h12);
    repeat (1200) @(posedge clk);
    u_host.rd(ADDR_FLAGS, rv);
    chk("no_reset", rv, 8'h82);
    u_host.rd(ADDR_OPT1, rv);
    chk("opt1_kept", rv, 8'h24);
    $display("test service and lock done");
    end_of_test();
  end
endmodule
`default_nettype wire
